// File: pkg/qawd_defines.svh
// Constants of the question-and-answer watchdog
`ifndef QAWD_DEFINES_SVH
`define QAWD_DEFINES_SVH
`define QAWD_MODE_MULTI        1'b0
`define QAWD_MODE_SINGLE       1'b1
`define QAWD_FAIL_CNT_RST      4'h5
`define QAWD_DRV_TH_RST        4'h5
`define QAWD_RST_TH_RST        4'hf
`define QAWD_RST_EN_RST        1'b1
`define QAWD_FAIL_CNT_MAX      4'hf
`define QAWD_FAIL_CNT_MIN      4'h0
`define QAWD_ANSW_CNT_START    2'h3
`define QAWD_ANSW_CNT_SINGLE   2'h1
`define QAWD_QUESTION_SEED     4'h1
`define QAWD_CLK_HZ            25000000
`define QAWD_STEP_NS           550000
`define QAWD_STEP_CYCLES       ((`QAWD_STEP_NS * (`QAWD_CLK_HZ / 1000000)) / 1000)
`endif

// File: pkg/qawd_pkg.sv
// Types of the question-and-answer watchdog
package qawd_pkg;
  typedef enum logic [1:0] {
    ST_OTHER,
    ST_DIAGNOSTIC,
    ST_ACTIVE,
    ST_SAFE
  } qawd_opstate_type;

  typedef struct packed {
    logic       mode_select;
    logic [7:0] first_window;
    logic [4:0] second_window;
    logic [7:0] answer_generation;
  } qawd_cfg_type;

  typedef struct packed {
    logic       fail_flag;
    logic       timeout_flag;
    logic [1:0] answer_counter;
    logic [3:0] failure_counter;
    logic [3:0] question;
  } qawd_status_type;
endpackage

// File: rtl/qawd_step_timer.sv
// Window step timer: one pulse every window step
`timescale 1ns/100ps
module qawd_step_timer #(
  parameter int STEP_CYCLES = 13750
) (
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic restart_in,
  output logic      step_out
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk_in) begin
    if (!rstn_in || restart_in || step_out) begin
      cnt_q <= 16'h0;
    end else begin
      cnt_q <= cnt_q + 16'h1;
    end
  end

  assign step_out = (cnt_q == 16'(STEP_CYCLES - 1));
endmodule

// File: rtl/qawd_watchdog.sv
// Question-and-answer watchdog with failure counter
`timescale 1ns/100ps
`include "qawd_defines.svh"
// Functional notes
// - Mode bit 0 selects multi-answer mode, 1 selects single-answer mode.
// - Pending 4-bit question is readable; answers arrive as answer writes.
// - Multi-answer set correct only with right values, order and windows.
// - Single answer correct only with right value inside open window.
// - Early, late, miscalculated or misordered answers are wrong.
// - An expired second window restarts run; outside ST_OTHER it also sets timeout flag and counts one failure.
// - Mode, window or generation config change counts failure and restarts.
// - Correct answer decrements failure counter; wrong answer increments it.
// - Failure counter updates only in diagnostic, active or safe states.
// - Counter below driver threshold keeps safing driver available.
// - Counter above driver threshold forces safing driver pin low.
// - Safing driver works only after software sets its enable bit.
// - Every failure counter increment sets the fail flag.
// - With reset-on-fail enabled, reaching reset threshold pulls MCU reset low.
// - Reset-on-fail enable resets to one.
// - Power-on reset loads failure counter with five.
// - Thresholds writable in diagnostic; new driver threshold loads counter.
// - Failure counter saturates at fifteen and at zero.
// - Window length is field plus one times a 0.55 ms step.
// - Multi-answer answer counter starts at three, decrements per answer.
// - Three answers in window one, the fourth in window two.
// - No answer in close window; one correct answer in open window.
module qawd_watchdog
  import qawd_pkg::*;
#(
  parameter int STEP_CYCLES = `QAWD_STEP_CYCLES
) (
  // Clock and reset
  input  wire logic                    CLK_IN,
  input  wire logic                    RSTN_IN,
  // Device state and configuration
  input  wire qawd_pkg::qawd_opstate_type OPSTATE_IN,
  input  wire qawd_pkg::qawd_cfg_type  CFG_IN,
  input  wire logic                    SAFING_DRIVER_ENABLE_IN,
  input  wire logic                    RESET_ON_FAIL_ENABLE_WR_IN,
  input  wire logic                    RESET_ON_FAIL_ENABLE_IN,
  // Threshold writes
  input  wire logic                    DRV_TH_WR_IN,
  input  wire logic [3:0]              DRV_TH_IN,
  input  wire logic                    RST_TH_WR_IN,
  input  wire logic [3:0]              RST_TH_IN,
  // Answer register write
  input  wire logic                    ANSWER_WR_IN,
  input  wire logic [7:0]              ANSWER_IN,
  // Status clear
  input  wire logic                    STATUS_CLR_IN,
  // Status and pins
  output qawd_pkg::qawd_status_type    STATUS_OUT,
  output logic [3:0]                   DRV_TH_OUT,
  output logic [3:0]                   RST_TH_OUT,
  output logic                         RESET_ON_FAIL_ENABLE_OUT,
  output logic                         SAFING_DRIVER_PIN_OUT,
  output logic                         MCU_RESET_PIN_N_OUT
);
  import qawd_pkg::*;

  typedef enum logic [1:0] {WIN_FIRST, WIN_SECOND} qawd_win_type;

  // Registered state
  qawd_win_type win_q;
  qawd_cfg_type cfg_q;
  logic [7:0]   win_cnt_q;
  logic [3:0]   question_q;
  logic [1:0]   answer_counter_q;
  logic         set_bad_q;
  logic [3:0]   failure_counter_q;
  logic [3:0]   drv_th_q;
  logic [3:0]   rst_th_q;
  logic         rst_en_q;
  logic         timeout_q;
  logic         fail_q;

  // Decoded conditions
  logic         step;
  logic         cfg_change;
  logic         win_end;
  logic         timeout;
  logic         restart;
  logic [7:0]   expected;
  logic         value_ok;
  logic         in_window;
  logic         answer_good;
  logic         answer_bad;
  logic         set_done;
  logic         set_good;
  logic         cnt_inc;
  logic         cnt_dec;
  logic         cnt_live;
  logic         multi_mode;
  logic         next_multi;
  logic         answer_wr_multi;
  logic         drv_th_take;
  logic         rst_th_take;
  logic         fc_at_top;
  logic         fc_at_bottom;
  logic [7:0]   win_last;
  logic [3:0]   question_next;

  assign cfg_change = (CFG_IN != cfg_q);
  assign multi_mode      = (cfg_q.mode_select == `QAWD_MODE_MULTI);
  assign next_multi      = (CFG_IN.mode_select == `QAWD_MODE_MULTI);
  assign answer_wr_multi = ANSWER_WR_IN && multi_mode;
  assign drv_th_take     = DRV_TH_WR_IN && (OPSTATE_IN == ST_DIAGNOSTIC);
  assign rst_th_take     = RST_TH_WR_IN && (OPSTATE_IN == ST_DIAGNOSTIC);
  assign fc_at_top       = (failure_counter_q == `QAWD_FAIL_CNT_MAX);
  assign fc_at_bottom    = (failure_counter_q == `QAWD_FAIL_CNT_MIN);

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= CFG_IN;
    end
  end

  qawd_step_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_step (
    .clk_in     (CLK_IN),
    .rstn_in    (RSTN_IN),
    .restart_in (restart),
    .step_out   (step)
  );

  // Window lengths in steps
  assign win_last = (win_q == WIN_FIRST) ? cfg_q.first_window
                                         : {3'h0, cfg_q.second_window};
  assign win_end  = step && (win_cnt_q == win_last);

  // Expected answer: simple mix of question, slot and generation setting
  assign expected = {question_q ^ cfg_q.answer_generation[7:4],
                     question_q ^ {answer_counter_q, answer_counter_q}} ^ cfg_q.answer_generation;
  assign value_ok = (ANSWER_IN == expected);
  assign question_next = (question_q == 4'h0) ? `QAWD_QUESTION_SEED
                         : {question_q[2:0], question_q[3] ^ question_q[2]};

  always_comb begin
    if (cfg_q.mode_select == `QAWD_MODE_MULTI) begin
      in_window = (win_q == WIN_FIRST) ? (answer_counter_q != 2'h0)
                                       : (answer_counter_q == 2'h0);
    end else begin
      in_window = (win_q == WIN_SECOND);
    end
  end

  // Multi: judge the whole set at the last answer; single: judge each write
  assign set_done    = ANSWER_WR_IN && (cfg_q.mode_select == `QAWD_MODE_MULTI)
                       && (answer_counter_q == 2'h0);
  assign set_good    = set_done && !set_bad_q && value_ok && in_window;
  assign answer_good = (cfg_q.mode_select == `QAWD_MODE_SINGLE)
                       ? (ANSWER_WR_IN && value_ok && in_window) : set_good;
  assign answer_bad  = (cfg_q.mode_select == `QAWD_MODE_SINGLE)
                       ? (ANSWER_WR_IN && !(value_ok && in_window))
                       : (set_done && !set_good);
  // Answer on the last window edge is still in time
  assign timeout     = win_end && (win_q == WIN_SECOND) && !cfg_change
                       && !answer_good && !answer_bad;
  assign restart     = cfg_change || timeout || answer_good || answer_bad;

  // Window sequencing
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || restart) begin
      win_q <= WIN_FIRST;
    end else if (win_end) begin
      win_q <= WIN_SECOND;
    end
  end

  // Steps inside the current window
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || restart || win_end) begin
      win_cnt_q <= 8'h0;
    end else if (step) begin
      win_cnt_q <= win_cnt_q + 8'h1;
    end
  end

  // Answer counter per run
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || restart) begin
      answer_counter_q <= next_multi ? `QAWD_ANSW_CNT_START
                                     : `QAWD_ANSW_CNT_SINGLE;
    end else if (answer_wr_multi) begin
      answer_counter_q <= answer_counter_q - 2'h1;
    end
  end

  // Spoilt-set marker
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || restart) begin
      set_bad_q <= 1'b0;
    end else if (answer_wr_multi) begin
      set_bad_q <= set_bad_q || !value_ok || !in_window;
    end
  end

  // Question advances after each correct sequence
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      question_q <= `QAWD_QUESTION_SEED;
    end else if (answer_good) begin
      question_q <= question_next;
    end
  end

  // Failure counter
  assign cnt_live = (OPSTATE_IN == ST_DIAGNOSTIC) || (OPSTATE_IN == ST_ACTIVE)
                    || (OPSTATE_IN == ST_SAFE);
  assign cnt_inc  = cnt_live && (answer_bad || timeout || cfg_change);
  assign cnt_dec  = cnt_live && answer_good && !cnt_inc;

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      failure_counter_q <= `QAWD_FAIL_CNT_RST;
    end else if (drv_th_take) begin
      failure_counter_q <= DRV_TH_IN;
    end else if (cnt_inc && !fc_at_top) begin
      failure_counter_q <= failure_counter_q + 4'h1;
    end else if (cnt_dec && !fc_at_bottom) begin
      failure_counter_q <= failure_counter_q - 4'h1;
    end
  end

  // Driver-disable threshold
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      drv_th_q <= `QAWD_DRV_TH_RST;
    end else if (drv_th_take) begin
      drv_th_q <= DRV_TH_IN;
    end
  end

  // Reset threshold
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      rst_th_q <= `QAWD_RST_TH_RST;
    end else if (rst_th_take) begin
      rst_th_q <= RST_TH_IN;
    end
  end

  // Reset-on-fail enable
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      rst_en_q <= `QAWD_RST_EN_RST;
    end else if (RESET_ON_FAIL_ENABLE_WR_IN) begin
      rst_en_q <= RESET_ON_FAIL_ENABLE_IN;
    end
  end

  // Timeout flag, set wins over clear
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= (timeout_q && !STATUS_CLR_IN) || (timeout && cnt_live);
    end
  end

  // Fail flag, set wins over clear
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      fail_q <= 1'b0;
    end else begin
      fail_q <= (fail_q && !STATUS_CLR_IN) || cnt_inc;
    end
  end

  // Safing driver pin
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      SAFING_DRIVER_PIN_OUT <= 1'b0;
    end else begin
      SAFING_DRIVER_PIN_OUT <= SAFING_DRIVER_ENABLE_IN
                               && (failure_counter_q < drv_th_q);
    end
  end

  // Microcontroller reset pin
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      MCU_RESET_PIN_N_OUT <= 1'b0;
    end else begin
      MCU_RESET_PIN_N_OUT <= !(rst_en_q && (failure_counter_q >= rst_th_q));
    end
  end

  assign STATUS_OUT = '{fail_flag:       fail_q,
                        timeout_flag:    timeout_q,
                        answer_counter:  answer_counter_q,
                        failure_counter: failure_counter_q,
                        question:        question_q};
  assign DRV_TH_OUT = drv_th_q;
  assign RST_TH_OUT = rst_th_q;
  assign RESET_ON_FAIL_ENABLE_OUT = rst_en_q;
endmodule

// File: verif/qawd_mcu_model.sv
// Microcontroller model that answers watchdog questions
`timescale 1ns/100ps
module qawd_mcu_model
  import qawd_pkg::*;
(
  input  wire logic                      clk_in,
  input  wire qawd_pkg::qawd_status_type status_in,
  input  wire logic [7:0]                ag_in,
  output logic                           wr_out,
  output logic [7:0]                     data_out
);
  initial begin
    wr_out = 1'b0;
    data_out = 8'h00;
  end
  // One answer write, bit 0 spoilt on request, then data inverted
  task automatic send(input logic bad);
    @(negedge clk_in);
    wr_out = 1'b1;
    data_out = {status_in.question ^ ag_in[7:4],
      status_in.question ^ {2{status_in.answer_counter}}} ^ ag_in ^ {7'h00, bad};
    @(negedge clk_in);
    wr_out = 1'b0;
    data_out = ~data_out;
    @(negedge clk_in);
  endtask
endmodule

// File: verif/qawd_watchdog_sva.sv
// Checker for the watchdog failure counter and pins
`timescale 1ns/100ps
module qawd_watchdog_sva
  import qawd_pkg::*;
(
  input wire logic                       CLK_IN,
  input wire logic                       RSTN_IN,
  input wire qawd_pkg::qawd_opstate_type OPSTATE_IN,
  input wire logic                       SAFING_DRIVER_ENABLE_IN,
  input wire logic                       DRV_TH_WR_IN,
  input wire logic [3:0]                 DRV_TH_IN,
  input wire qawd_pkg::qawd_status_type  STATUS_OUT,
  input wire logic [3:0]                 DRV_TH_OUT,
  input wire logic [3:0]                 RST_TH_OUT,
  input wire logic                       RESET_ON_FAIL_ENABLE_OUT,
  input wire logic                       SAFING_DRIVER_PIN_OUT,
  input wire logic                       MCU_RESET_PIN_N_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  wire [3:0] fc = STATUS_OUT.failure_counter;
  fc_step_a: assert property (
    !$past(DRV_TH_WR_IN) |-> fc - $past(fc) <= 4'h1 || $past(fc) - fc <= 4'h1)
    else $error("failure counter jumped");
  fail_flag_a: assert property (
    fc > $past(fc) && !$past(DRV_TH_WR_IN) |-> STATUS_OUT.fail_flag)
    else $error("fail flag missing");
  fc_frozen_a: assert property (OPSTATE_IN == ST_OTHER |=> $stable(fc))
    else $error("counter moved while frozen");
  th_load_a: assert property (DRV_TH_WR_IN && OPSTATE_IN == ST_DIAGNOSTIC
    |=> fc == $past(DRV_TH_IN) && DRV_TH_OUT == $past(DRV_TH_IN))
    else $error("threshold load wrong");
  th_refuse_a: assert property (
    DRV_TH_WR_IN && OPSTATE_IN != ST_DIAGNOSTIC |=> $stable(DRV_TH_OUT))
    else $error("threshold write not refused");
  safing_pin_a: assert property ($past(RSTN_IN) && $stable(SAFING_DRIVER_ENABLE_IN)
    |-> SAFING_DRIVER_PIN_OUT == (SAFING_DRIVER_ENABLE_IN && $past(fc) < $past(DRV_TH_OUT)))
    else $error("safing pin wrong");
  mcu_reset_a: assert property ($past(RSTN_IN) |-> MCU_RESET_PIN_N_OUT ==
    !($past(RESET_ON_FAIL_ENABLE_OUT) && $past(fc) >= $past(RST_TH_OUT)))
    else $error("reset pin wrong");
  timeout_count_a: assert property ($rose(STATUS_OUT.timeout_flag)
    && $past(OPSTATE_IN) != ST_OTHER |-> fc == ($past(fc) == 4'hf ? 4'hf : $past(fc) + 4'h1))
    else $error("timeout count wrong");
  timeout_c: cover property ($rose(STATUS_OUT.timeout_flag));
  top_c: cover property (fc == 4'hf);
  zero_c: cover property (fc == 4'h0 && SAFING_DRIVER_PIN_OUT);
endmodule
bind qawd_watchdog qawd_watchdog_sva qawd_watchdog_sva_i (.CLK_IN, .RSTN_IN, .OPSTATE_IN,
  .SAFING_DRIVER_ENABLE_IN, .DRV_TH_WR_IN, .DRV_TH_IN, .STATUS_OUT, .DRV_TH_OUT,
  .RST_TH_OUT, .RESET_ON_FAIL_ENABLE_OUT, .SAFING_DRIVER_PIN_OUT, .MCU_RESET_PIN_N_OUT);

// File: verif/qa_watchdog_fail_counter_tb_top.sv
// Testbench for the question-and-answer watchdog
`timescale 1ns/100ps
module qa_watchdog_fail_counter_tb_top;
  import qawd_pkg::*;
  logic clk, rstn, en, rwr, ren, dwr, rswr, clr, awr, ren_o, safe_o, mcu_reset_pin_o;
  logic [3:0] dth, rth, drv_o, rst_o, exp_fc, qfc[$];
  logic [7:0] adat;
  qawd_opstate_type st;
  qawd_cfg_type cfg;
  qawd_status_type stat;
  int n_fail, checks_done, seed;
  event smp;
  qawd_watchdog #(.STEP_CYCLES(4)) qawd_watchdog_i (.CLK_IN(clk), .RSTN_IN(rstn),
    .OPSTATE_IN(st), .CFG_IN(cfg), .SAFING_DRIVER_ENABLE_IN(en),
    .RESET_ON_FAIL_ENABLE_WR_IN(rwr), .RESET_ON_FAIL_ENABLE_IN(ren), .DRV_TH_WR_IN(dwr),
    .DRV_TH_IN(dth), .RST_TH_WR_IN(rswr), .RST_TH_IN(rth), .ANSWER_WR_IN(awr),
    .ANSWER_IN(adat), .STATUS_CLR_IN(clr), .STATUS_OUT(stat), .DRV_TH_OUT(drv_o),
    .RST_TH_OUT(rst_o), .RESET_ON_FAIL_ENABLE_OUT(ren_o), .SAFING_DRIVER_PIN_OUT(safe_o),
    .MCU_RESET_PIN_N_OUT(mcu_reset_pin_o));
  qawd_mcu_model qawd_mcu_model_i (.clk_in(clk), .status_in(stat),
    .ag_in(cfg.answer_generation), .wr_out(awr), .data_out(adat));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Note the expected counter, then let the watcher compare
  task automatic note(input int d);
    if (d > 0 && exp_fc != 4'hf) exp_fc++;
    if (d < 0 && exp_fc != 4'h0) exp_fc--;
    qfc.push_back(exp_fc);
    tick(2);
    ->smp;
  endtask
  always @(smp) chk(stat.failure_counter, qfc.pop_front());
  task automatic recfg(input logic m);
    cfg.mode_select = m;
    cfg.answer_generation += 8'h01 + {1'b0, 7'($random(seed))};
    note(1);
  endtask
  task automatic thw(input logic [3:0] v);
    dwr = 1'b1;
    dth = v;
    tick(1);
    dwr = 1'b0;
  endtask
  task automatic multi(input logic bad);
    repeat (3) qawd_mcu_model_i.send(1'b0);
    chk(4'(stat.answer_counter), 4'h0);
    tick(36);
    qawd_mcu_model_i.send(bad);
  endtask
  task automatic sgl(input logic bad);
    tick(38);
    qawd_mcu_model_i.send(bad);
  endtask
  task automatic final_report;
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    n_fail++;
    final_report();
  end
  initial begin
    seed = 83084;
    {rstn, en, rwr, ren, dwr, rswr, clr, dth, rth} = '0;
    st = ST_OTHER;
    cfg = '0;
    {n_fail, checks_done} = '0;
    exp_fc = 4'h5;
    tick(10);
    rstn = 1'b1;
    note(0);
    chk(drv_o, 4'h5);
    chk(rst_o, 4'hf);
    chk(4'(ren_o), 4'h1);
    chk(stat.question, 4'h1);
    chk(4'(mcu_reset_pin_o), 4'h1);
    cfg = '{1'b0, 8'h07, 5'h07, 8'h00};
    note(0);
    st = ST_DIAGNOSTIC;
    en = 1'b1;
    thw(4'h3);
    exp_fc = 4'h3;
    note(0);
    rth = 4'h8;
    rswr = 1'b1;
    tick(1);
    rswr = 1'b0;
    chk(rst_o, 4'h8);
    recfg(1'b0);
    chk(4'(stat.answer_counter), 4'h3);
    repeat (2) begin
      multi(1'b0);
      note(-1);
    end
    chk(stat.question, 4'h4);
    multi(1'b1);
    note(1);
    chk(4'(stat.fail_flag), 4'h1);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(1);
    chk(4'(stat.fail_flag), 4'h0);
    repeat (4) qawd_mcu_model_i.send(1'b0);
    note(1);
    recfg(1'b0);
    tick(64);
    note(1);
    chk(4'(stat.timeout_flag), 4'h1);
    recfg(1'b1);
    chk(4'(stat.answer_counter), 4'h1);
    sgl(1'b0);
    note(-1);
    qawd_mcu_model_i.send(1'b0);
    note(1);
    recfg(1'b1);
    chk(4'(mcu_reset_pin_o), 4'h0);
    chk(4'(safe_o), 4'h0);
    rwr = 1'b1;
    tick(1);
    rwr = 1'b0;
    tick(2);
    chk(4'(mcu_reset_pin_o), 4'h1);
    sgl(1'b1);
    note(1);
    repeat (8) recfg(1'b1);
    thw(4'h1);
    exp_fc = 4'h1;
    note(0);
    chk(4'(safe_o), 4'h0);
    recfg(1'b1);
    repeat (3) begin
      sgl(1'b0);
      note(-1);
    end
    chk(4'(safe_o), 4'h1);
    en = 1'b0;
    tick(3);
    chk(4'(safe_o), 4'h0);
    st = ST_ACTIVE;
    thw(4'h9);
    tick(2);
    chk(drv_o, 4'h1);
    final_report();
  end
endmodule
